// ---- src/csc_defines.svh ----
// Purpose: Shared constants of the clock-source control and monitor block.
// Assumes: A 10 MHz block clock.
// Notes:   Timing counts are derived from times in nanoseconds.
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// Clock output select encodings; 4'h0 to 4'h3 give no clock.
`define CSC_CKOUT_SYS        4'h4
`define CSC_CKOUT_INTERNAL_RC_8M      4'h5
`define CSC_CKOUT_HIGH_SPEED_CRYSTAL      4'h6
`define CSC_CKOUT_PLL_HALF   4'h7
`define CSC_CKOUT_PLL1       4'h8
`define CSC_CKOUT_PLL2_HALF  4'h9
`define CSC_CKOUT_EXTERNAL_SOURCE_ONE       4'ha
`define CSC_CKOUT_PLL2       4'hb

// Bit positions in the synchronised source vector.
`define CSC_SRC_LS_OSC     0
`define CSC_SRC_LS_PIN     1
`define CSC_SRC_HS_OSC     2
`define CSC_SRC_HS_PIN     3
`define CSC_SRC_INTERNAL_RC_8M      4
`define CSC_SRC_INTERNAL_RC_48M     5
`define CSC_SRC_INTERNAL_RC_40K     6
`define CSC_SRC_PLL        7
`define CSC_SRC_PLL_HALF   8
`define CSC_SRC_PLL1       9
`define CSC_SRC_PLL2_HALF  10
`define CSC_SRC_EXTERNAL_SOURCE_ONE       11
`define CSC_SRC_PLL2       12
`define CSC_SRC_PWR_GOOD   13
`define CSC_SRC_WIDTH      14

// Timing.
`define CSC_CLK_PERIOD_NS   100
`define CSC_LS_STABLE_EDGES 16'h0010
`define CSC_HS_FAIL_TIME_NS 2000
`define CSC_HS_FAIL_CYCLES \
   ((`CSC_HS_FAIL_TIME_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)

`endif

// ---- src/csc_pkg.sv ----
// Purpose: Types of the clock-source control and monitor block.
// Assumes: Nothing beyond the shared defines.
// Notes:   Encodings of the source selects are fixed here.
package csc_pkg;

   typedef enum logic [1:0] {
      CSC_SYS_INTERNAL_RC_8M = 2'b00,
      CSC_SYS_HIGH_SPEED_CRYSTAL = 2'b01,
      CSC_SYS_PLL   = 2'b10
   } csc_sys_src_e;

   typedef enum logic [1:0] {
      CSC_PREF_HIGH_SPEED_CRYSTAL  = 2'b00,
      CSC_PREF_INTERNAL_RC_8M  = 2'b01,
      CSC_PREF_INTERNAL_RC_48M = 2'b10
   } csc_pll_ref_e;

   typedef enum logic [1:0] {
      CSC_RTC_NONE   = 2'b00,
      CSC_RTC_LOW_SPEED_CRYSTAL  = 2'b01,
      CSC_RTC_INTERNAL_RC_40K = 2'b10,
      CSC_RTC_HIGH_SPEED_CRYSTAL  = 2'b11
   } csc_rtc_src_e;

   typedef enum logic [1:0] {
      CSC_LS_OFF      = 2'b00,
      CSC_LS_STARTING = 2'b01,
      CSC_LS_STABLE   = 2'b10
   } csc_ls_state_e;

   typedef logic [3:0] csc_ckout_sel_t;

endpackage

// ---- src/csc_sync.sv ----
// Purpose: Two-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is unrelated to the others.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module csc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire  logic             clk,
   input  wire  logic             resetn,
   // Data
   input  wire  logic [WIDTH-1:0] async_in,
   output var   logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule
`default_nettype wire

// ---- src/csc_top.sv ----
// Purpose: Clock-source control, clock output selection and crystal monitor.
// Assumes: Sources arrive as pins sampled at 10 MHz; bits are plain ports.
// Notes:   Clock paths are modelled as sampled levels, not glitch-free muxes.
`include "csc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Clock output carries the source picked by the 4-bit output select.
// - Low-speed oscillator runs while its enable bit is set.
// - A read-only flag shows the low-speed clock has become stable.
// - Stable event interrupts only while its interrupt enable is 1.
// - Bypass with enable takes the low-speed pin directly as clock.
// - High-speed clock comes from its pin only when bypass is set.
// - Loop reference is high-speed crystal, 8 MHz RC or 48 MHz RC.
// - Monitored crystal failure stops the crystal and sets failure flag.
// - Crystal failure raises a non-maskable interrupt request.
// - Failure moves a crystal-fed system clock to the 8 MHz RC.
// - Failure disables a crystal-fed loop; software redoes RTC source.
// - RTC on 40 kHz RC stops without main power, then resumes.
module csc_top
   import csc_pkg::*;
#(
   parameter int RTC_WIDTH = 32
) (
   // Clock and reset
   input  wire  logic                   clk,
   input  wire  logic                   resetn,
   // Software control
   input  wire  logic                   low_speed_osc_enable,
   input  wire  logic                   low_speed_bypass,
   input  wire  logic                   low_speed_stable_irq_enable,
   input  wire  logic                   low_speed_stable_clear,
   input  wire  logic                   high_speed_osc_enable,
   input  wire  logic                   high_speed_bypass,
   input  wire  logic                   clock_monitor_enable,
   input  wire  logic                   clock_failure_clear,
   input  wire  csc_pkg::csc_sys_src_e  sys_source_select,
   input  wire  csc_pkg::csc_pll_ref_e  pll_ref_select,
   input  wire  logic                   pll_enable,
   input  wire  csc_pkg::csc_rtc_src_e  rtc_source_select,
   input  wire  csc_pkg::csc_ckout_sel_t clock_output_select,
   // Source pins
   input  wire  logic                   low_speed_osc_in,
   input  wire  logic                   low_speed_pin_in,
   input  wire  logic                   high_speed_osc_in,
   input  wire  logic                   high_speed_pin_in,
   input  wire  logic                   internal_rc_8m_in,
   input  wire  logic                   internal_rc_48m_in,
   input  wire  logic                   internal_rc_40k_in,
   input  wire  logic                   pll_in,
   input  wire  logic                   pll_half_in,
   input  wire  logic                   second_loop_in,
   input  wire  logic                   third_loop_half_in,
   input  wire  logic                   external_source_one_in,
   input  wire  logic                   third_loop_in,
   input  wire  logic                   main_power_good,
   // Oscillator and loop controls
   output logic                         low_speed_osc_run,
   output logic                         high_speed_osc_run,
   output logic                         pll_run,
   output csc_pkg::csc_sys_src_e        sys_source_active,
   // Clocks
   output logic                         low_speed_clock,
   output logic                         high_speed_clock,
   output logic                         pll_ref_clock,
   output logic                         system_clock,
   output logic                         clock_output,
   // Status and events
   output logic                         low_speed_stable_flag,
   output logic                         low_speed_stable_irq,
   output logic                         clock_failure_flag,
   output logic                         nmi_request,
   output logic                         rtc_source_lost,
   output logic [RTC_WIDTH-1:0]         rtc_count
);

   import csc_pkg::*;

   localparam logic [15:0] HS_FAIL_CYCLES = 16'(`CSC_HS_FAIL_CYCLES);

   logic [`CSC_SRC_WIDTH-1:0] src;
   csc_ls_state_e             ls_state;
   logic [15:0]               ls_edges;
   logic                      ls_prev;
   logic                      hs_prev;
   logic [15:0]               hs_idle;
   logic                      hs_failed;
   logic                      fail_event;
   logic                      ls_stable_event;
   logic                      next_ls_clock;
   logic                      next_hs_clock;
   logic                      rtc_clk_sel;
   logic                      rtc_prev;

   ////////////////////////////////////////////////////////////////////////
   // Every source pin passes two flops before any logic looks at it.
   csc_sync #(
      .WIDTH (`CSC_SRC_WIDTH)
   ) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({main_power_good, third_loop_in, external_source_one_in,
                  third_loop_half_in, second_loop_in, pll_half_in, pll_in,
                  internal_rc_40k_in, internal_rc_48m_in, internal_rc_8m_in,
                  high_speed_pin_in, high_speed_osc_in, low_speed_pin_in,
                  low_speed_osc_in}),
      .sync_out (src)
   );

   ////////////////////////////////////////////////////////////////////////
   // Low-speed oscillator.
   always_comb begin
      if (!low_speed_osc_run)
         next_ls_clock = 1'b0;
      else if (low_speed_bypass)
         next_ls_clock = src[`CSC_SRC_LS_PIN];
      else
         next_ls_clock = src[`CSC_SRC_LS_OSC];
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         low_speed_osc_run <= 1'b0;
         low_speed_clock   <= 1'b0;
         ls_prev           <= 1'b0;
      end else begin
         low_speed_osc_run <= low_speed_osc_enable;
         low_speed_clock   <= next_ls_clock;
         ls_prev           <= low_speed_clock;
      end
   end

   // Stability is judged by a run of clock edges after start.
   assign ls_stable_event = (ls_state == CSC_LS_STARTING) &&
                            (ls_edges == `CSC_LS_STABLE_EDGES);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ls_state <= CSC_LS_OFF;
         ls_edges <= 16'h0000;
      end else begin
         case (ls_state)
            CSC_LS_OFF: begin
               ls_edges <= 16'h0000;
               if (low_speed_osc_run)
                  ls_state <= CSC_LS_STARTING;
            end
            CSC_LS_STARTING: begin
               if (!low_speed_osc_run)
                  ls_state <= CSC_LS_OFF;
               else if (ls_stable_event)
                  ls_state <= CSC_LS_STABLE;
               else if (low_speed_clock && !ls_prev)
                  ls_edges <= ls_edges + 16'h0001;
            end
            CSC_LS_STABLE: begin
               if (!low_speed_osc_run)
                  ls_state <= CSC_LS_OFF;
            end
            default: ls_state <= CSC_LS_OFF;
         endcase
      end
   end

   // A new stable event wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         low_speed_stable_flag <= 1'b0;
         low_speed_stable_irq  <= 1'b0;
      end else begin
         low_speed_stable_flag <= ls_stable_event ||
            (low_speed_stable_flag && !low_speed_stable_clear &&
             low_speed_osc_run);
         low_speed_stable_irq  <= low_speed_stable_irq_enable &&
            (ls_stable_event ||
             (low_speed_stable_irq && !low_speed_stable_clear));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // High-speed crystal and its failure monitor.
   always_comb begin
      if (!high_speed_osc_run)
         next_hs_clock = 1'b0;
      else if (high_speed_bypass)
         next_hs_clock = src[`CSC_SRC_HS_PIN];
      else
         next_hs_clock = src[`CSC_SRC_HS_OSC];
   end

   // The monitor only counts while software says start-up is over.
   assign fail_event = clock_monitor_enable && high_speed_osc_run &&
                       (hs_idle == HS_FAIL_CYCLES);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         high_speed_clock <= 1'b0;
         hs_prev          <= 1'b0;
         hs_idle          <= 16'h0000;
      end else begin
         high_speed_clock <= next_hs_clock;
         hs_prev          <= high_speed_clock;
         if (!clock_monitor_enable || !high_speed_osc_run ||
             (high_speed_clock != hs_prev))
            hs_idle <= 16'h0000;
         else if (hs_idle != HS_FAIL_CYCLES)
            hs_idle <= hs_idle + 16'h0001;
      end
   end

   // The crystal stays off after a failure until the flag is cleared.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hs_failed          <= 1'b0;
         high_speed_osc_run <= 1'b0;
         clock_failure_flag <= 1'b0;
         nmi_request        <= 1'b0;
         rtc_source_lost    <= 1'b0;
      end else begin
         hs_failed          <= fail_event ||
                               (hs_failed && !clock_failure_clear);
         high_speed_osc_run <= high_speed_osc_enable && !fail_event &&
                               !hs_failed;
         clock_failure_flag <= fail_event ||
            (clock_failure_flag && !clock_failure_clear);
         nmi_request        <= fail_event;
         rtc_source_lost    <= (fail_event &&
                                rtc_source_select == CSC_RTC_HIGH_SPEED_CRYSTAL) ||
            (rtc_source_lost && !clock_failure_clear);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System clock and loop.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sys_source_active <= CSC_SYS_INTERNAL_RC_8M;
         pll_run           <= 1'b0;
      end else begin
         if ((fail_event || hs_failed) &&
             sys_source_select == CSC_SYS_HIGH_SPEED_CRYSTAL)
            sys_source_active <= CSC_SYS_INTERNAL_RC_8M;
         else
            sys_source_active <= sys_source_select;
         pll_run <= pll_enable && !((fail_event || hs_failed) &&
                    pll_ref_select == CSC_PREF_HIGH_SPEED_CRYSTAL);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pll_ref_clock <= 1'b0;
         system_clock  <= 1'b0;
      end else begin
         case (pll_ref_select)
            CSC_PREF_HIGH_SPEED_CRYSTAL:  pll_ref_clock <= high_speed_clock;
            CSC_PREF_INTERNAL_RC_8M:  pll_ref_clock <= src[`CSC_SRC_INTERNAL_RC_8M];
            CSC_PREF_INTERNAL_RC_48M: pll_ref_clock <= src[`CSC_SRC_INTERNAL_RC_48M];
            default:         pll_ref_clock <= 1'b0;
         endcase
         case (sys_source_active)
            CSC_SYS_HIGH_SPEED_CRYSTAL: system_clock <= high_speed_clock;
            CSC_SYS_PLL:   system_clock <= pll_run && src[`CSC_SRC_PLL];
            default:       system_clock <= src[`CSC_SRC_INTERNAL_RC_8M];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock output selector; the pin mux itself lies outside.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         clock_output <= 1'b0;
      end else begin
         case (clock_output_select)
            `CSC_CKOUT_SYS:       clock_output <= system_clock;
            `CSC_CKOUT_INTERNAL_RC_8M:     clock_output <= src[`CSC_SRC_INTERNAL_RC_8M];
            `CSC_CKOUT_HIGH_SPEED_CRYSTAL:     clock_output <= high_speed_clock;
            `CSC_CKOUT_PLL_HALF:  clock_output <= src[`CSC_SRC_PLL_HALF];
            `CSC_CKOUT_PLL1:      clock_output <= src[`CSC_SRC_PLL1];
            `CSC_CKOUT_PLL2_HALF: clock_output <= src[`CSC_SRC_PLL2_HALF];
            `CSC_CKOUT_EXTERNAL_SOURCE_ONE:      clock_output <= src[`CSC_SRC_EXTERNAL_SOURCE_ONE];
            `CSC_CKOUT_PLL2:      clock_output <= src[`CSC_SRC_PLL2];
            default:              clock_output <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Real-time counter. On the 40 kHz RC it holds while main power is
   // away; the low-speed and high-speed crystal sources are not gated by main power.
   always_comb begin
      case (rtc_source_select)
         CSC_RTC_LOW_SPEED_CRYSTAL:  rtc_clk_sel = low_speed_clock;
         CSC_RTC_INTERNAL_RC_40K: rtc_clk_sel = src[`CSC_SRC_INTERNAL_RC_40K] &&
                                       src[`CSC_SRC_PWR_GOOD];
         CSC_RTC_HIGH_SPEED_CRYSTAL:  rtc_clk_sel = high_speed_clock;
         default:        rtc_clk_sel = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rtc_prev  <= 1'b0;
         rtc_count <= '0;
      end else begin
         rtc_prev <= rtc_clk_sel;
         if (rtc_clk_sel && !rtc_prev)
            rtc_count <= rtc_count + RTC_WIDTH'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_fail;
      fail_event;
   endsequence

   sequence s_fail_effects;
      ##1 clock_failure_flag && nmi_request && !high_speed_osc_run;
   endsequence

   AST_CKOUT_OFF: assert property (@(posedge clk) disable iff (!resetn)
      clock_output_select[3:2] == 2'b00 |=> !clock_output)
      else $error("Clock output active with no source selected");
   AST_CKOUT_INTERNAL_RC_8M: assert property (@(posedge clk) disable iff (!resetn)
      clock_output_select == `CSC_CKOUT_INTERNAL_RC_8M |=>
         clock_output == $past(src[`CSC_SRC_INTERNAL_RC_8M]))
      else $error("Clock output does not follow the 8 MHz RC");
   AST_LS_RUN: assert property (@(posedge clk) disable iff (!resetn)
      low_speed_osc_enable |=> low_speed_osc_run)
      else $error("Low-speed oscillator not started");
   AST_LS_FLAG: assert property (@(posedge clk) disable iff (!resetn)
      ls_stable_event |=> low_speed_stable_flag [*2])
      else $error("Stable flag not held after stable event");
   AST_LS_IRQ: assert property (@(posedge clk) disable iff (!resetn)
      low_speed_stable_irq |-> $past(low_speed_stable_irq_enable))
      else $error("Stable interrupt without enable");
   AST_LS_BYPASS: assert property (@(posedge clk) disable iff (!resetn)
      low_speed_osc_run && low_speed_bypass |=>
         low_speed_clock == $past(src[`CSC_SRC_LS_PIN]))
      else $error("Bypass low-speed clock not taken from pin");
   AST_HS_BYPASS: assert property (@(posedge clk) disable iff (!resetn)
      high_speed_osc_run && !high_speed_bypass |=>
         high_speed_clock == $past(src[`CSC_SRC_HS_OSC]))
      else $error("High-speed clock taken from pin without bypass");
   AST_FAIL: assert property (@(posedge clk) disable iff (!resetn)
      s_fail |-> s_fail_effects)
      else $error("Crystal failure not handled");
   AST_NMI_CAUSE: assert property (@(posedge clk) disable iff (!resetn)
      nmi_request |-> $past(clock_monitor_enable) && $rose(clock_failure_flag)
         || $past(clock_failure_flag))
      else $error("Non-maskable request without failure");
   AST_SYS_FALLBACK: assert property (@(posedge clk) disable iff (!resetn)
      s_fail ##0 sys_source_select == CSC_SYS_HIGH_SPEED_CRYSTAL |=>
         sys_source_active == CSC_SYS_INTERNAL_RC_8M)
      else $error("System clock not moved to 8 MHz RC");
   AST_PLL_OFF: assert property (@(posedge clk) disable iff (!resetn)
      hs_failed && pll_ref_select == CSC_PREF_HIGH_SPEED_CRYSTAL |=> !pll_run)
      else $error("Loop still running on failed crystal");
   AST_RTC_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      rtc_source_select == CSC_RTC_INTERNAL_RC_40K && !src[`CSC_SRC_PWR_GOOD]
         |=> $stable(rtc_count))
      else $error("RTC counted on 40 kHz RC without power");

endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the clock-source control block.
// Assumes: Sources are static levels or slow pulses, far below 10 MHz.
// Notes:   Inputs change on the falling edge; outputs are read there too.
`include "csc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module tb;
   import csc_pkg::*;

   typedef struct {
      logic [3:0] sel;
      int         idx;
      logic       mapped;
   } csc_row_s;

   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   logic                ls_en = 1'b0, ls_bps = 1'b0, ls_ie = 1'b0;
   logic                ls_clr = 1'b0, hs_en = 1'b0, hs_bps = 1'b0;
   logic                mon_en = 1'b0, fail_clr = 1'b0, pll_en = 1'b0;
   csc_sys_src_e        sys_sel = CSC_SYS_INTERNAL_RC_8M;
   csc_pll_ref_e        ref_sel = CSC_PREF_HIGH_SPEED_CRYSTAL;
   csc_rtc_src_e        rtc_sel = CSC_RTC_NONE;
   csc_ckout_sel_t      out_sel = 4'h0;
   logic [13:0]         pins = 14'h0000;
   logic                ls_run, hs_run, pll_run, ls_clk, hs_clk, ref_clk;
   logic                sys_clk, ck_out, ls_flag, ls_irq, fail_flag, nmi;
   logic                rtc_lost;
   csc_sys_src_e        sys_act;
   logic [31:0]         rtc_cnt, c0;
   int                  n_errors = 0;
   int                  n_checks = 0;
   int                  k;
   int                  ref_idx [3] = '{`CSC_SRC_HS_OSC, `CSC_SRC_INTERNAL_RC_8M,
                                        `CSC_SRC_INTERNAL_RC_48M};
   csc_row_s            rows [12] = '{
      '{4'h4, `CSC_SRC_INTERNAL_RC_8M, 1'b1}, '{4'h5, `CSC_SRC_INTERNAL_RC_8M, 1'b1},
      '{4'h6, `CSC_SRC_HS_OSC, 1'b1}, '{4'h7, `CSC_SRC_PLL_HALF, 1'b1},
      '{4'h8, `CSC_SRC_PLL1, 1'b1}, '{4'h9, `CSC_SRC_PLL2_HALF, 1'b1},
      '{4'ha, `CSC_SRC_EXTERNAL_SOURCE_ONE, 1'b1}, '{4'hb, `CSC_SRC_PLL2, 1'b1},
      '{4'h0, `CSC_SRC_INTERNAL_RC_8M, 1'b0}, '{4'h1, `CSC_SRC_INTERNAL_RC_8M, 1'b0},
      '{4'h2, `CSC_SRC_HS_OSC, 1'b0}, '{4'h3, `CSC_SRC_PLL2, 1'b0}};

   always #50 clk = ~clk;

   csc_top u_dut (
      .clk(clk), .resetn(resetn),
      .low_speed_osc_enable(ls_en), .low_speed_bypass(ls_bps),
      .low_speed_stable_irq_enable(ls_ie), .low_speed_stable_clear(ls_clr),
      .high_speed_osc_enable(hs_en), .high_speed_bypass(hs_bps),
      .clock_monitor_enable(mon_en), .clock_failure_clear(fail_clr),
      .sys_source_select(sys_sel), .pll_ref_select(ref_sel),
      .pll_enable(pll_en), .rtc_source_select(rtc_sel),
      .clock_output_select(out_sel),
      .low_speed_osc_in(pins[`CSC_SRC_LS_OSC]),
      .low_speed_pin_in(pins[`CSC_SRC_LS_PIN]),
      .high_speed_osc_in(pins[`CSC_SRC_HS_OSC]),
      .high_speed_pin_in(pins[`CSC_SRC_HS_PIN]),
      .internal_rc_8m_in(pins[`CSC_SRC_INTERNAL_RC_8M]),
      .internal_rc_48m_in(pins[`CSC_SRC_INTERNAL_RC_48M]),
      .internal_rc_40k_in(pins[`CSC_SRC_INTERNAL_RC_40K]),
      .pll_in(pins[`CSC_SRC_PLL]), .pll_half_in(pins[`CSC_SRC_PLL_HALF]),
      .second_loop_in(pins[`CSC_SRC_PLL1]),
      .third_loop_half_in(pins[`CSC_SRC_PLL2_HALF]),
      .external_source_one_in(pins[`CSC_SRC_EXTERNAL_SOURCE_ONE]),
      .third_loop_in(pins[`CSC_SRC_PLL2]),
      .main_power_good(pins[`CSC_SRC_PWR_GOOD]),
      .low_speed_osc_run(ls_run), .high_speed_osc_run(hs_run),
      .pll_run(pll_run), .sys_source_active(sys_act),
      .low_speed_clock(ls_clk), .high_speed_clock(hs_clk),
      .pll_ref_clock(ref_clk), .system_clock(sys_clk),
      .clock_output(ck_out), .low_speed_stable_flag(ls_flag),
      .low_speed_stable_irq(ls_irq), .clock_failure_flag(fail_flag),
      .nmi_request(nmi), .rtc_source_lost(rtc_lost), .rtc_count(rtc_cnt));

   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Slow pulses: each level lasts two cycles so no edge is lost in sync.
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         pins[idx] = 1'b1;
         cyc(2);
         pins[idx] = 1'b0;
         cyc(2);
      end
   endtask

   task automatic wrap_up;
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(4);
      `CHK("reset_run", 1'b0, ls_run | hs_run | pll_run | nmi);
      cyc(1);
      resetn = 1'b1;
      hs_en = 1'b1;
      foreach (rows[i]) begin
         out_sel = rows[i].sel;
         pins = 14'h0000;
         pins[rows[i].idx] = 1'b1;
         cyc(8);
         `CHK("clock_output_hi", rows[i].mapped, ck_out);
         pins = ~pins;
         cyc(8);
         `CHK("clock_output_lo", 1'b0, ck_out);
      end
      pins = 14'h0000;
      ls_en = 1'b1;
      cyc(1);
      `CHK("ls_run_on", 1'b1, ls_run);
      pulse(`CSC_SRC_LS_OSC, 18);
      cyc(4);
      `CHK("ls_flag", 1'b1, ls_flag);
      `CHK("ls_irq_masked", 1'b0, ls_irq);
      ls_en = 1'b0;
      cyc(2);
      `CHK("ls_run_off", 1'b0, ls_run);
      ls_ie = 1'b1;
      ls_en = 1'b1;
      cyc(2);
      `CHK("ls_flag_early", 1'b0, ls_flag);
      pulse(`CSC_SRC_LS_OSC, 18);
      cyc(4);
      `CHK("ls_irq", 1'b1, ls_irq);
      ls_clr = 1'b1;
      cyc(1);
      ls_clr = 1'b0;
      cyc(2);
      `CHK("ls_irq_clr", 1'b0, ls_irq);
      ls_bps = 1'b1;
      pins[`CSC_SRC_LS_PIN] = 1'b1;
      cyc(5);
      `CHK("ls_clk_bypass", 1'b1, ls_clk);
      ls_bps = 1'b0;
      cyc(5);
      `CHK("ls_clk_osc", 1'b0, ls_clk);
      hs_bps = 1'b1;
      pins[`CSC_SRC_HS_PIN] = 1'b1;
      cyc(5);
      `CHK("hs_clk_bypass", 1'b1, hs_clk);
      hs_bps = 1'b0;
      cyc(5);
      `CHK("hs_clk_osc", 1'b0, hs_clk);
      for (int r = 0; r < 3; r++) begin
         ref_sel = csc_pll_ref_e'(r[1:0]);
         pins = 14'h0000;
         pins[ref_idx[r]] = 1'b1;
         cyc(8);
         `CHK("pll_ref_hi", 1'b1, ref_clk);
         pins = ~pins;
         cyc(8);
         `CHK("pll_ref_lo", 1'b0, ref_clk);
      end
      pins = 14'h0000;
      pins[`CSC_SRC_PWR_GOOD] = 1'b1;
      rtc_sel = CSC_RTC_INTERNAL_RC_40K;
      cyc(4);
      c0 = rtc_cnt;
      pulse(`CSC_SRC_INTERNAL_RC_40K, 5);
      cyc(4);
      `CHK("rtc_run", c0 + 32'h5, rtc_cnt);
      pins[`CSC_SRC_PWR_GOOD] = 1'b0;
      cyc(4);
      c0 = rtc_cnt;
      pulse(`CSC_SRC_INTERNAL_RC_40K, 5);
      cyc(4);
      `CHK("rtc_hold", c0, rtc_cnt);
      pins[`CSC_SRC_PWR_GOOD] = 1'b1;
      cyc(4);
      pulse(`CSC_SRC_INTERNAL_RC_40K, 3);
      cyc(4);
      `CHK("rtc_resume", c0 + 32'h3, rtc_cnt);
      // On battery alone the low-speed crystal keeps the count going.
      pins[`CSC_SRC_PWR_GOOD] = 1'b0;
      rtc_sel = CSC_RTC_LOW_SPEED_CRYSTAL;
      cyc(4);
      c0 = rtc_cnt;
      pulse(`CSC_SRC_LS_OSC, 3);
      cyc(4);
      `CHK("rtc_battery", c0 + 32'h3, rtc_cnt);
      ref_sel = CSC_PREF_HIGH_SPEED_CRYSTAL;
      sys_sel = CSC_SYS_HIGH_SPEED_CRYSTAL;
      rtc_sel = CSC_RTC_HIGH_SPEED_CRYSTAL;
      pll_en = 1'b1;
      cyc(3);
      `CHK("sys_on_crystal", CSC_SYS_HIGH_SPEED_CRYSTAL, sys_act);
      // Monitoring starts only once the crystal is running.
      mon_en = 1'b1;
      k = 0;
      while (nmi !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      if (k >= 40) begin
         n_errors++;
         $display("ERROR nmi_wait expected 1 seen 0");
         wrap_up();
      end
      `CHK("fail_flag", 1'b1, fail_flag);
      `CHK("hs_run_off", 1'b0, hs_run);
      `CHK("sys_fallback", CSC_SYS_INTERNAL_RC_8M, sys_act);
      `CHK("pll_off", 1'b0, pll_run);
      `CHK("rtc_lost", 1'b1, rtc_lost);
      cyc(1);
      `CHK("nmi_pulse", 1'b0, nmi);
      mon_en = 1'b0;
      fail_clr = 1'b1;
      cyc(1);
      fail_clr = 1'b0;
      cyc(2);
      `CHK("fail_clr", 1'b0, fail_flag);
      `CHK("hs_restart", 1'b1, hs_run);
      // A second reset in mid-run must clear the counter and the flags.
      resetn = 1'b0;
      cyc(3);
      `CHK("reset_mid_cnt", 32'h0, rtc_cnt);
      `CHK("reset_mid_flag", 1'b0, ls_flag | fail_flag | rtc_lost);
      resetn = 1'b1;
      cyc(2);
      `CHK("reset_mid_run", 1'b1, ls_run);
      wrap_up();
   end
endmodule

`undef CHK
`default_nettype wire
